// ==== rtl/hba_pkg.sv ====
// package: register map, timing counts and carrier types of the host bus block
`default_nettype none
package hba_pkg;
   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_SCSI_CONTROL_ZERO   = 8'h00;
   localparam logic [7:0] OFS_SCSI_CONTROL_ONE    = 8'h01;
   localparam logic [7:0] OFS_DESTINATION_ID      = 8'h02;
   localparam logic [7:0] OFS_SCSI_IRQ_ENABLE     = 8'h03;
   localparam logic [7:0] OFS_OWN_CHIP_ID         = 8'h04;
   localparam logic [7:0] OFS_TRANSFER_CONFIG     = 8'h05;
   localparam logic [7:0] OFS_OUTPUT_DATA_LATCH   = 8'h06;
   localparam logic [7:0] OFS_OUTPUT_CONTROL_LATCH = 8'h07;
   localparam logic [7:0] OFS_FIRST_BYTE_RECEIVED = 8'h08;
   localparam logic [7:0] OFS_INPUT_DATA_LATCH    = 8'h09;
   localparam logic [7:0] OFS_BUS_DATA_LINES      = 8'h0a;
   localparam logic [7:0] OFS_BUS_CONTROL_LINES   = 8'h0b;
   localparam logic [7:0] OFS_DMA_STATUS          = 8'h0c;
   localparam logic [7:0] OFS_SCSI_STATUS_ZERO    = 8'h0d;
   localparam logic [7:0] OFS_SCSI_STATUS_ONE     = 8'h0e;
   localparam logic [7:0] OFS_SCSI_STATUS_TWO     = 8'h0f;
   localparam logic [7:0] OFS_INTERRUPT_STATUS    = 8'h21;
   localparam logic [7:0] OFS_DMA_IRQ_ENABLE      = 8'h39;

   // ----------------------------------------------------------------
   // fields and reset values
   // ----------------------------------------------------------------
   localparam int         INTERRUPT_STATUS_DMA_PEND_BIT  = 0;
   localparam int         INTERRUPT_STATUS_SCSI_PEND_BIT = 1;
   localparam logic [7:0] INTERRUPT_STATUS_SW_MASK       = 8'hfc;
   localparam logic [7:0] REG_RESET           = 8'h00;

   // ----------------------------------------------------------------
   // timing counts
   // ----------------------------------------------------------------
   localparam int CLKS_PER_BUS_STATE = 2;
   localparam int IRQ_GAP_CLKS       = 3;
   localparam int FAIR_BUS_STATES    = 8;
   localparam int CHAIN_BUS_STATES   = 2;
   localparam int REQ_LOW_MIN_CLKS   = 2;
   localparam int FAIR_GAP_CLKS      = FAIR_BUS_STATES * CLKS_PER_BUS_STATE;
   localparam int CHAIN_GAP_CLKS     = (CHAIN_BUS_STATES * CLKS_PER_BUS_STATE
                                        > REQ_LOW_MIN_CLKS) ?
                                       CHAIN_BUS_STATES * CLKS_PER_BUS_STATE :
                                       REQ_LOW_MIN_CLKS;
   localparam int GAP_CNT_W          = 5;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum {SLV_IDLE, SLV_ARMED, SLV_DATA} hba_slv_e;
   typedef enum {ARB_IDLE, ARB_REQ, ARB_MASTER, ARB_PASS, ARB_GAP} hba_arb_e;

   // read-only scsi side values shown to the host
   typedef struct packed {
      logic [7:0] first_byte_received;
      logic [7:0] input_data_latch;
      logic [7:0] bus_data_lines;
      logic [7:0] bus_control_lines;
      logic [7:0] scsi_status_one;
      logic [7:0] scsi_status_two;
   } hba_scsi_view_s;

   // writable control registers handed to the core
   typedef struct packed {
      logic [7:0] scsi_control_zero;
      logic [7:0] scsi_control_one;
      logic [7:0] destination_id;
      logic [7:0] scsi_irq_enable;
      logic [7:0] own_chip_id;
      logic [7:0] transfer_config;
      logic [7:0] output_data_latch;
      logic [7:0] output_control_latch;
      logic [7:0] interrupt_status;
      logic [7:0] dma_irq_enable;
   } hba_ctrl_s;
endpackage
`default_nettype wire

// ==== rtl/hba_sync.sv ====
// two-flop synchroniser for a group of pin inputs
`default_nettype none
module hba_sync #(
   parameter int              WIDTH     = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   // clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_reset_n,
   // data
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         meta_q <= RESET_VAL;
         sync_q <= RESET_VAL;
      end else begin
         meta_q <= i_async;
         sync_q <= meta_q;
      end
   end

   assign o_sync = sync_q;
endmodule // hba_sync
`default_nettype wire

// ==== rtl/hba_irq_gap.sv ====
// interrupt output with enforced release gap
`default_nettype none
module hba_irq_gap #(
   parameter int GAP_CLKS = 3,
   parameter int CNT_W    = 3
) (
   // clock and reset
   input  wire logic i_clk,
   input  wire logic i_reset_n,
   // control
   input  wire logic i_pending,
   input  wire logic i_release,
   // pin
   output logic      o_irq_n
);
   localparam logic [CNT_W-1:0] GAP_LAST = CNT_W'(GAP_CLKS);

   logic             irq_q;
   logic [CNT_W-1:0] gap_q;

   // ----------------------------------------------------------------
   // gap counter and output flop
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         irq_q <= 1'b0;
         gap_q <= GAP_LAST;
      end else if (irq_q && (i_release || !i_pending)) begin
         irq_q <= 1'b0;
         gap_q <= '0;
      end else if (!irq_q) begin
         if (gap_q != GAP_LAST) begin
            gap_q <= gap_q + CNT_W'(1);
         end
         irq_q <= (gap_q == GAP_LAST) && i_pending && !i_release;
      end
   end

   assign o_irq_n = !irq_q;
endmodule // hba_irq_gap
`default_nettype wire

// ==== rtl/hba_host_port.sv ====
// host bus slave, interrupt output and bus arbitration of the io processor
//
// Contract
// - reading dma status or scsi status zero releases the interrupt output.
// - release follows the clock edge where ready input is sampled active.
// - stacked interrupts keep the interrupt released at least 3 clocks.
// - slave access only when chip select seen at phase one after strobe.
// - next-address input ignored during slave cycles, no pipelined slave addressing.
// - mastership taken on the next phase-one edge after grant sampled.
// - grant and chained request inputs pass synchronisers before use.
// - after dropping request, wait 8 bus states before own re-request.
// - with chained request pending, wait only 2 bus states.
// - bus request stays low at least 2 clocks before rising again.
// - request bus for fetch or block move; drive only after grant.
// - own request beats simultaneous chained request.
// - grant passed to chained grant output when own need absent.
`default_nettype none
module hba_host_port
   import hba_pkg::*;
(
   // clock and reset
   input  wire logic                    i_clk,
   input  wire logic                    i_reset_n,
   // host slave pins
   input  wire logic                    i_address_strobe_n,
   input  wire logic                    i_host_chip_select_n,
   input  wire logic                    i_next_address_n,
   input  wire logic                    i_ready_in_n,
   input  wire logic                    i_write,
   input  wire logic [7:0]              i_addr,
   input  wire logic [7:0]              i_wdata,
   output logic      [7:0]              o_rdata,
   output logic                         o_rdata_oe,
   output logic                         o_ready_out_n,
   output logic                         o_irq_n,
   // arbitration pins
   input  wire logic                    i_bus_grant_in,
   input  wire logic                    i_chained_request_in,
   output logic                         o_bus_request,
   output logic                         o_chained_grant_out,
   // core side
   input  wire logic                    i_need_bus,
   input  wire logic [7:0]              i_dma_event,
   input  wire logic [7:0]              i_scsi_event,
   input  wire hba_pkg::hba_scsi_view_s i_scsi_view,
   output hba_pkg::hba_ctrl_s           o_ctrl,
   output logic                         o_bus_master,
   output logic                         o_early_address
);
   import hba_pkg::*;

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   logic       ads_n_s;
   logic       hcs_n_s;
   logic       na_n_s;
   logic       rdy_n_s;
   logic       write_s;
   logic [7:0] addr_s;
   logic [7:0] wdata_s;
   logic       grant_s;
   logic       chain_req_s;

   hba_sync #(.WIDTH(4), .RESET_VAL(4'hf)) u_sync_strobes (
      .i_clk     (i_clk),
      .i_reset_n (i_reset_n),
      .i_async   ({i_address_strobe_n, i_host_chip_select_n,
                   i_next_address_n, i_ready_in_n}),
      .o_sync    ({ads_n_s, hcs_n_s, na_n_s, rdy_n_s})
   );

   hba_sync #(.WIDTH(17), .RESET_VAL(17'h0)) u_sync_bus (
      .i_clk     (i_clk),
      .i_reset_n (i_reset_n),
      .i_async   ({i_write, i_addr, i_wdata}),
      .o_sync    ({write_s, addr_s, wdata_s})
   );

   hba_sync #(.WIDTH(2), .RESET_VAL(2'h0)) u_sync_arb (
      .i_clk     (i_clk),
      .i_reset_n (i_reset_n),
      .i_async   ({i_bus_grant_in, i_chained_request_in}),
      .o_sync    ({grant_s, chain_req_s})
   );

   // ----------------------------------------------------------------
   // phase tracking
   // ----------------------------------------------------------------
   logic ph1_q;
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ph1_q <= 1'b1;
      end else begin
         ph1_q <= !ph1_q;
      end
   end

   // ----------------------------------------------------------------
   // slave cycle state machine
   // ----------------------------------------------------------------
   hba_slv_e   slv_q;
   logic       slv_wr_q;
   logic [7:0] slv_addr_q;
   logic [7:0] slv_wdata_q;
   logic       slv_start;
   logic       slv_end;
   logic       status_rd_end;
   // chip select checked at first phase-one edge
   assign slv_start = (slv_q == SLV_ARMED) && ph1_q && !hcs_n_s;
   // cycle ends on sampled ready input
   assign slv_end   = (slv_q == SLV_DATA) && !rdy_n_s;
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         slv_q <= SLV_IDLE;
      end else begin
         case (slv_q)
            SLV_IDLE: begin
               if (!ads_n_s) begin
                  slv_q <= SLV_ARMED;
               end
            end
            SLV_ARMED: begin
               if (ph1_q) begin
                  slv_q <= hcs_n_s ? SLV_IDLE : SLV_DATA;
               end
            end
            SLV_DATA: begin
               if (!rdy_n_s) begin
                  slv_q <= SLV_IDLE;
               end
            end
            default: begin
               slv_q <= SLV_IDLE;
            end
         endcase
      end
   end
   // address taken once, next-address never looked at here
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         slv_wr_q    <= 1'b0;
         slv_addr_q  <= 8'h00;
         slv_wdata_q <= 8'h00;
      end else if (slv_start) begin
         slv_wr_q    <= write_s;
         slv_addr_q  <= addr_s;
         slv_wdata_q <= wdata_s;
      end
   end
   assign o_ready_out_n = !(slv_q == SLV_DATA);
   assign o_rdata_oe    = (slv_q == SLV_DATA) && !slv_wr_q;

   // ----------------------------------------------------------------
   // writable registers
   // ----------------------------------------------------------------
   logic [7:0] ctl_q [8];
   logic [7:0] interrupt_status_sw_q;
   logic [7:0] dma_irq_enable_q;
   logic       wr_commit;
   assign wr_commit = slv_end && slv_wr_q;
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         for (int i = 0; i < 8; i++) begin
            ctl_q[i] <= REG_RESET;
         end
      end else if (wr_commit && (slv_addr_q[7:3] == 5'h00)) begin
         ctl_q[slv_addr_q[2:0]] <= slv_wdata_q;
      end
   end
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         interrupt_status_sw_q <= REG_RESET;
         dma_irq_enable_q     <= REG_RESET;
      end else if (wr_commit) begin
         if (slv_addr_q == OFS_INTERRUPT_STATUS) begin
            interrupt_status_sw_q <= slv_wdata_q & INTERRUPT_STATUS_SW_MASK;
         end
         if (slv_addr_q == OFS_DMA_IRQ_ENABLE) begin
            dma_irq_enable_q <= slv_wdata_q;
         end
      end
   end

   // ----------------------------------------------------------------
   // sticky status, cleared by a completed read
   // ----------------------------------------------------------------
   logic [7:0] dma_status_q;
   logic [7:0] scsi_status_zero_q;
   logic       clr_dma_status;
   logic       clr_scsi_status_zero;
   // reads of either status register clear it
   assign clr_dma_status     = slv_end && !slv_wr_q && (slv_addr_q == OFS_DMA_STATUS);
   assign clr_scsi_status_zero    = slv_end && !slv_wr_q && (slv_addr_q == OFS_SCSI_STATUS_ZERO);
   assign status_rd_end = clr_dma_status || clr_scsi_status_zero;
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         dma_status_q  <= REG_RESET;
         scsi_status_zero_q <= REG_RESET;
      end else begin
         dma_status_q  <= (dma_status_q & ~{8{clr_dma_status}}) | i_dma_event;
         scsi_status_zero_q <= (scsi_status_zero_q & ~{8{clr_scsi_status_zero}}) | i_scsi_event;
      end
   end

   // ----------------------------------------------------------------
   // interrupt output
   // ----------------------------------------------------------------
   logic dma_pend;
   logic scsi_pend;
   assign dma_pend  = |(dma_status_q & dma_irq_enable_q);
   assign scsi_pend = |(scsi_status_zero_q & ctl_q[OFS_SCSI_IRQ_ENABLE[2:0]]);
   // release on status read, then hold off 4 clocks
   hba_irq_gap #(.GAP_CLKS(IRQ_GAP_CLKS), .CNT_W(3)) u_irq (
      .i_clk     (i_clk),
      .i_reset_n (i_reset_n),
      .i_pending (dma_pend || scsi_pend),
      .i_release (status_rd_end),
      .o_irq_n   (o_irq_n)
   );

   // ----------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------
   logic [7:0] interrupt_status_view;
   logic [7:0] rd_d;
   logic [7:0] rdata_q;
   always_comb begin
      interrupt_status_view                      = interrupt_status_sw_q;
      interrupt_status_view[INTERRUPT_STATUS_DMA_PEND_BIT]  = dma_pend;
      interrupt_status_view[INTERRUPT_STATUS_SCSI_PEND_BIT] = scsi_pend;
   end
   always_comb begin
      case (addr_s)
         OFS_SCSI_CONTROL_ZERO, OFS_SCSI_CONTROL_ONE, OFS_DESTINATION_ID,
         OFS_SCSI_IRQ_ENABLE, OFS_OWN_CHIP_ID, OFS_TRANSFER_CONFIG,
         OFS_OUTPUT_DATA_LATCH, OFS_OUTPUT_CONTROL_LATCH: begin
            rd_d = ctl_q[addr_s[2:0]];
         end
         OFS_FIRST_BYTE_RECEIVED: rd_d = i_scsi_view.first_byte_received;
         OFS_INPUT_DATA_LATCH:    rd_d = i_scsi_view.input_data_latch;
         OFS_BUS_DATA_LINES:      rd_d = i_scsi_view.bus_data_lines;
         OFS_BUS_CONTROL_LINES:   rd_d = i_scsi_view.bus_control_lines;
         OFS_DMA_STATUS:          rd_d = dma_status_q;
         OFS_SCSI_STATUS_ZERO:    rd_d = scsi_status_zero_q;
         OFS_SCSI_STATUS_ONE:     rd_d = i_scsi_view.scsi_status_one;
         OFS_SCSI_STATUS_TWO:     rd_d = i_scsi_view.scsi_status_two;
         OFS_INTERRUPT_STATUS:    rd_d = interrupt_status_view;
         OFS_DMA_IRQ_ENABLE:      rd_d = dma_irq_enable_q;
         default:                 rd_d = 8'h00;
      endcase
   end
   // captured at cycle start so status bits are not torn mid-read
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rdata_q <= 8'h00;
      end else if (slv_start) begin
         rdata_q <= rd_d;
      end
   end
   assign o_rdata = rdata_q;
   assign o_ctrl = '{
      scsi_control_zero:    ctl_q[0],
      scsi_control_one:     ctl_q[1],
      destination_id:       ctl_q[2],
      scsi_irq_enable:      ctl_q[3],
      own_chip_id:          ctl_q[4],
      transfer_config:      ctl_q[5],
      output_data_latch:    ctl_q[6],
      output_control_latch: ctl_q[7],
      interrupt_status:     interrupt_status_view,
      dma_irq_enable:       dma_irq_enable_q
   };

   // ----------------------------------------------------------------
   // bus arbitration
   // ----------------------------------------------------------------
   localparam logic [GAP_CNT_W-1:0] FAIR_LAST  = GAP_CNT_W'(FAIR_GAP_CLKS - 1);
   localparam logic [GAP_CNT_W-1:0] CHAIN_LAST = GAP_CNT_W'(CHAIN_GAP_CLKS - 1);
   hba_arb_e             arb_q;
   logic [GAP_CNT_W-1:0] gap_q;
   logic                 gap_done;
   // fairness gap, shortened by chained request
   assign gap_done = (gap_q >= FAIR_LAST) || (chain_req_s && (gap_q >= CHAIN_LAST));
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         gap_q <= '0;
      end else if (arb_q == ARB_GAP) begin
         if (gap_q != FAIR_LAST) begin
            gap_q <= gap_q + GAP_CNT_W'(1);
         end
      end else begin
         gap_q <= '0;
      end
   end
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         arb_q <= ARB_IDLE;
      end else begin
         case (arb_q)
            // own need checked before chained request
            ARB_IDLE: begin
               if (i_need_bus) begin
                  arb_q <= ARB_REQ;
               end else if (chain_req_s) begin
                  arb_q <= ARB_PASS;
               end
            end
            // mastership on phase-one edge after grant
            ARB_REQ: begin
               if (grant_s && ph1_q) begin
                  arb_q <= ARB_MASTER;
               end else if (!i_need_bus && !grant_s) begin
                  arb_q <= ARB_GAP;
               end
            end
            ARB_MASTER: begin
               if (!i_need_bus) begin
                  arb_q <= ARB_GAP;
               end
            end
            // pass grant unless own need arrives first
            ARB_PASS: begin
               if (!chain_req_s) begin
                  arb_q <= ARB_GAP;
               end else if (i_need_bus && !grant_s) begin
                  arb_q <= ARB_REQ;
               end
            end
            ARB_GAP: begin
               if (gap_done) begin
                  arb_q <= ARB_IDLE;
               end
            end
            default: begin
               arb_q <= ARB_IDLE;
            end
         endcase
      end
   end
   assign o_bus_request       = (arb_q == ARB_REQ) || (arb_q == ARB_MASTER) ||
                                (arb_q == ARB_PASS);
   assign o_chained_grant_out = (arb_q == ARB_PASS) && grant_s;
   assign o_bus_master        = (arb_q == ARB_MASTER);

   // ----------------------------------------------------------------
   // pipelined next address as master
   // ----------------------------------------------------------------
   logic early_q;
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         early_q <= 1'b0;
      end else begin
         early_q <= (arb_q == ARB_MASTER) && !na_n_s;
      end
   end

   assign o_early_address = early_q && (arb_q == ARB_MASTER);
endmodule // hba_host_port
`default_nettype wire

// ==== test/hba_host_port_properties.sv ====
// checker: pin timing relations of the host port
`default_nettype none
module hba_host_port_properties (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   // observed pins
   input wire logic i_host_chip_select_n,
   input wire logic i_ready_in_n,
   input wire logic i_bus_grant_in,
   input wire logic i_next_address_n,
   input wire logic o_ready_out_n,
   input wire logic o_irq_n,
   input wire logic o_bus_request,
   input wire logic o_chained_grant_out,
   input wire logic o_bus_master,
   input wire logic o_early_address
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   a_irq_gap: assert property ($rose(o_irq_n) |-> o_irq_n [*3])
      else $error("irq gap short");
   a_req_gap: assert property ($fell(o_bus_request) |-> !o_bus_request [*4])
      else $error("request gap short");
   a_slave_cs: assert property ($fell(o_ready_out_n) |->
      !$past(i_host_chip_select_n, 2) || !$past(i_host_chip_select_n, 3))
      else $error("slave cycle without select");
   a_ready_end: assert property ($rose(o_ready_out_n) |->
      !$past(i_ready_in_n, 2) || !$past(i_ready_in_n, 3))
      else $error("slave cycle ended early");
   a_master_grant: assert property ($rose(o_bus_master) |-> $past(i_bus_grant_in, 3))
      else $error("master without grant");
   a_grant_pass: assert property (o_chained_grant_out |->
      o_bus_request && !o_bus_master && $past(i_bus_grant_in, 2))
      else $error("grant passed while master");
   a_master_req: assert property (o_bus_master |-> o_bus_request)
      else $error("master without request");
   a_early_master: assert property (o_early_address |->
      o_bus_master && !$past(i_next_address_n, 3))
      else $error("early address outside mastership");
   c_irq: cover property ($fell(o_irq_n));
   c_slave: cover property ($fell(o_ready_out_n));
   c_pass: cover property ($rose(o_chained_grant_out));
endmodule // hba_host_port_properties
`default_nettype wire

// ==== test/hba_arbiter_model.sv ====
// arbiter model: grants the hold request promptly or after a delay
`default_nettype none
module hba_arbiter_model (
   // clock and reset
   input  wire logic i_clk,
   input  wire logic i_reset_n,
   // hold handshake
   input  wire logic i_request,
   input  wire logic i_slow,
   output logic      o_grant
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] wait_q;
   // grant drops with the request
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n || !i_request) begin
         wait_q  <= 4'h0;
         o_grant <= 1'b0;
      end else begin
         if (wait_q != 4'hf) wait_q <= wait_q + 4'h1;
         o_grant <= wait_q >= (i_slow ? 4'h6 : 4'h0);
      end
   end
endmodule // hba_arbiter_model
`default_nettype wire

// ==== test/tb_hba_host_port.sv ====
// testbench: register, interrupt and arbitration scenarios of the host port
`default_nettype none
module tb_hba_host_port;
   timeunit 1ns;
   timeprecision 1ps;
   import hba_pkg::*;
   logic i_clk, i_reset_n, i_address_strobe_n, i_host_chip_select_n, i_next_address_n;
   logic i_ready_in_n, i_write, i_need_bus, i_chained_request_in, i_bus_grant_in, slow;
   logic [7:0] i_addr, i_wdata, o_rdata, i_dma_event, i_scsi_event;
   logic o_rdata_oe, o_ready_out_n, o_irq_n, o_bus_request, o_chained_grant_out;
   logic o_bus_master, o_early_address;
   logic [4:0] mon;
   hba_scsi_view_s i_scsi_view;
   hba_ctrl_s o_ctrl;
   int fail_count = 0, checked = 0, cycles = 0, hi_run = 0, last_run = 0;
   assign mon = {o_chained_grant_out, o_bus_master, o_bus_request, o_irq_n, o_ready_out_n};
   hba_host_port i_hba_host_port (.i_clk, .i_reset_n, .i_address_strobe_n,
      .i_host_chip_select_n, .i_next_address_n, .i_ready_in_n, .i_write, .i_addr, .i_wdata,
      .o_rdata, .o_rdata_oe, .o_ready_out_n, .o_irq_n, .i_bus_grant_in, .i_chained_request_in,
      .o_bus_request, .o_chained_grant_out, .i_need_bus, .i_dma_event, .i_scsi_event,
      .i_scsi_view, .o_ctrl, .o_bus_master, .o_early_address);
   hba_arbiter_model i_hba_arbiter_model (.i_clk, .i_reset_n, .i_request(o_bus_request),
      .i_slow(slow), .o_grant(i_bus_grant_in));
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wait_bit(input int b, input logic v, input int lim, output int n);
      n = 0;
      while (mon[b] !== v && n < lim) begin
         @(negedge i_clk);
         n++;
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
      int n;
      @(negedge i_clk);
      i_address_strobe_n = 0;
      i_host_chip_select_n = 0;
      i_next_address_n = 0;
      i_write = w;
      i_addr = a;
      i_wdata = d;
      wait_bit(0, 0, 20, n);
      q = o_rdata;
      check({o_ready_out_n, o_early_address, o_rdata_oe}, {2'b00, !w});
      i_address_strobe_n = 1;
      i_ready_in_n = 0;
      wait_bit(0, 1, 20, n);
      check(o_ready_out_n, 1);
      i_ready_in_n = 1;
      i_host_chip_select_n = 1;
      i_next_address_n = 1;
      repeat (4) @(negedge i_clk);
   endtask
   task automatic t_regs;
      logic [7:0] q, a, m;
      for (int i = 0; i < 10; i++) begin
         a = (i < 8) ? 8'(i) : ((i == 8) ? OFS_INTERRUPT_STATUS : OFS_DMA_IRQ_ENABLE);
         m = (i == 8) ? INTERRUPT_STATUS_SW_MASK : 8'hff;
         bus(0, a, 8'h00, q);
         check(q, REG_RESET);
         bus(1, a, 8'ha5 ^ a, q);
         bus(0, a, 8'h00, q);
         check(q, (8'ha5 ^ a) & m);
      end
      check({o_ctrl.scsi_control_zero, o_ctrl.dma_irq_enable}, 16'ha59c);
      for (int i = 0; i < 7; i++) begin
         a = (i < 4) ? 8'h08 + 8'(i) : ((i < 6) ? 8'h0a + 8'(i) : 8'h40);
         bus(1, a, 8'hff, q);
         bus(0, a, 8'h00, q);
         check(q, (i < 6) ? 8'h11 * 8'(i + 1) : 8'h00);
      end
   endtask
   task automatic t_no_cs;
      int n;
      @(negedge i_clk);
      i_address_strobe_n = 0;
      repeat (2) @(negedge i_clk);
      i_address_strobe_n = 1;
      wait_bit(0, 0, 10, n);
      check(n, 10);
   endtask
   task automatic t_irq;
      logic [7:0] q;
      int n;
      bus(1, OFS_SCSI_IRQ_ENABLE, 8'h01, q);
      bus(1, OFS_DMA_IRQ_ENABLE, 8'h01, q);
      for (int k = 0; k < 3; k++) begin
         @(negedge i_clk);
         i_dma_event = (k != 1) ? 8'h01 : 8'h00;
         i_scsi_event = (k != 0) ? 8'h01 : 8'h00;
         @(negedge i_clk);
         i_dma_event = 8'h00;
         i_scsi_event = 8'h00;
         wait_bit(1, 0, 10, n);
         check(o_irq_n, 0);
         bus(0, (k == 1) ? OFS_SCSI_STATUS_ZERO : OFS_DMA_STATUS, 8'h00, q);
         check(q, 8'h01);
         if (k == 2) begin
            wait_bit(1, 0, 10, n);
            @(negedge i_clk);
            check(last_run >= IRQ_GAP_CLKS && !o_irq_n, 1);
            bus(0, OFS_SCSI_STATUS_ZERO, 8'h00, q);
            check(q, 8'h01);
         end
         check(o_irq_n, 1);
      end
   endtask
   task automatic t_arb;
      int n, lo, hi;
      @(negedge i_clk);
      i_need_bus = 1;
      wait_bit(3, 1, 20, n);
      check(o_bus_master, 1);
      i_next_address_n = 0;
      repeat (4) @(negedge i_clk);
      check(o_early_address, 1);
      i_next_address_n = 1;
      for (int k = 0; k < 2; k++) begin
         slow = k[0];
         i_need_bus = 0;
         wait_bit(2, 0, 10, n);
         i_chained_request_in = k[0];
         i_need_bus = 1;
         wait_bit(2, 1, 40, n);
         lo = (k ? CHAIN_GAP_CLKS : FAIR_GAP_CLKS) - 1;
         hi = k ? FAIR_GAP_CLKS - 4 : FAIR_GAP_CLKS + 4;
         check(n >= lo && n < hi, 1);
         wait_bit(3, 1, 20, n);
         check({o_bus_master, o_chained_grant_out}, 2'b10);
      end
      i_need_bus = 0;
      wait_bit(4, 1, 40, n);
      check({o_bus_master, o_chained_grant_out}, 2'b01);
      i_chained_request_in = 0;
      repeat (10) @(negedge i_clk);
   endtask
   initial begin
      i_clk = 0;
      forever #2 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      cycles <= cycles + 1;
      hi_run <= o_irq_n ? hi_run + 1 : 0;
      if (!o_irq_n && hi_run != 0) last_run <= hi_run;
      if (cycles == 20000) begin
         fail_count++;
         complete_run;
      end
   end
   initial begin
      {i_reset_n, i_write, i_need_bus, i_chained_request_in, slow} = 5'h00;
      {i_address_strobe_n, i_host_chip_select_n, i_next_address_n, i_ready_in_n} = 4'hf;
      {i_addr, i_wdata, i_dma_event, i_scsi_event} = 32'h0;
      i_scsi_view = 48'h112233445566;
      repeat (2) @(posedge i_clk);
      @(negedge i_clk);
      i_reset_n = 1;
      t_regs;
      t_no_cs;
      t_irq;
      t_arb;
      complete_run;
   end
endmodule // tb_hba_host_port
bind hba_host_port hba_host_port_properties i_hba_host_port_properties (.i_clk, .i_reset_n,
   .i_host_chip_select_n, .i_next_address_n, .i_ready_in_n, .i_bus_grant_in, .o_ready_out_n,
   .o_irq_n, .o_bus_request, .o_chained_grant_out, .o_bus_master, .o_early_address);
`default_nettype wire
